// ---- src/pin_level_filter.sv ----
/*
  Three-stage input filter for pins that arrive from outside the clock domain.
  Assumes each pin is slower than two clock periods per level.
*/
`timescale 1ns/10ps
module pin_level_filter #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);
  generate
    for (genvar g = 0; g < WIDTH; g++) begin : g_bit
      logic [2:0] stage_reg;
      logic level_reg;
      // The first stage feeds only the second; the level moves once stages two and three agree.
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          stage_reg <= 3'h0;
        end else begin
          stage_reg <= {stage_reg[1:0], i_pin[g]};
        end
      end
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          level_reg <= 1'b0;
        end else if (stage_reg[1] == stage_reg[2]) begin
          level_reg <= stage_reg[2];
        end
      end
      assign o_level[g] = level_reg;
    end
  endgenerate
endmodule

// ---- src/wdt_scaler_core.sv ----
/*
  Watchdog timer with a shared 8-bit scaler, timer zero and reset-cause flags,
  reached over AXI4-Lite. Assumes the core drives instruction pulses on i_clk,
  and that o_wdt_reset is fed back into the chip reset by the surrounding logic.
*/
// The AXI4-Lite interface to the registers is this design's own decision.
// What this block does and what software must do
// R1: One 8-bit scaler serves timer zero or the watchdog, never both.
// R2: Option bit 3 routes scaler: 0 timer zero, 1 watchdog; changeable anytime.
// R3: Ratio field divides timer zero 1:2..1:256, watchdog 1:1..1:128, doubling.
// R4: Clear-watchdog zeroes watchdog count and scaler when scaler serves watchdog.
// R5: Writing timer zero count zeroes scaler while scaler serves timer zero.
// R6: Sleep zeroes watchdog count, and scaler too when assigned to watchdog.
// R7: Watchdog runs on its own time base; overflow resets the chip.
// R8: Overflow period is 16 ms times ratio; 128 ms after any reset.
// R9: Timeout flag set by power-on, clear-watchdog, sleep; cleared by overflow.
// R10: Power-down flag set by power-on, clear-watchdog; cleared by sleep only.
// R11: Flags 00 wake from sleep, 01 running overflow, 11 power-on.
// R12: Software writes to status never change timeout or power-down flags.
// R13: Control bit 0 enables watchdog; resets to 0; upper bits read 0.
// R14: Factory configuration bit 1 forces watchdog on regardless of soft enable.
// R15: Edge select bit 4: 1 counts falling, 0 rising external edges.
// R16: Software moves scaler to watchdog via the safe eight-step sequence.
// R17: Software clears watchdog before moving scaler back to timer zero.
// R18: For undivided timer zero, software assigns scaler to the watchdog.
// R19: Software clears watchdog only from the main loop, not interrupts.
// R20: Watchdog reset keeps timeout and power-down flags readable afterwards.
`timescale 1ns/10ps
module wdt_scaler_core #(
  parameter int unsigned WDT_BASE_CYCLES_P = wdt_scaler_pkg::WDT_BASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [wdt_scaler_pkg::AXI_ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [wdt_scaler_pkg::AXI_DATA_W-1:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [wdt_scaler_pkg::AXI_ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [wdt_scaler_pkg::AXI_DATA_W-1:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_watchdog_clear_instr,
  input wire logic i_sleep_instr,
  input wire logic i_wake_event,
  input wire logic i_timer_zero_ext_clock,
  input wire logic i_config_wdt_enable,
  output logic o_wdt_reset,
  output logic o_sleeping,
  output logic o_timer_zero_overflow,
  output logic o_timeout_flag,
  output logic o_powerdown_flag
);
  import wdt_scaler_pkg::*;

  localparam logic [WDT_BASE_CNT_W-1:0] WDT_BASE_LAST = WDT_BASE_CNT_W'(WDT_BASE_CYCLES_P - 1);

  function automatic logic [REG_INDEX_W-1:0] reg_index(input logic [AXI_ADDR_W-1:0] addr);
    reg_index = addr[AXI_ADDR_W-1:2];
  endfunction

  // Terminal count of the scaler; the watchdog side starts at 1:1, timer zero at 1:2.
  function automatic logic [SCALER_W-1:0] ratio_mask(input logic [2:0] ratio, input logic for_wdt);
    logic [SCALER_W:0] span;
    span = for_wdt ? (9'h001 << ratio) : (9'h002 << ratio);
    ratio_mask = span[SCALER_W-1:0] - 8'h01;
  endfunction

  logic [7:0] option_reg;
  logic [7:0] watchdog_control_reg;
  logic [7:0] timer_zero_reg;
  logic [SCALER_W-1:0] scaler_reg;
  logic [WDT_BASE_CNT_W-1:0] base_cnt_reg;
  logic timeout_flag_reg;
  logic powerdown_flag_reg;
  logic sleeping_reg;
  logic wdt_reset_reg;
  logic t0_ovf_reg;
  logic ext_prev_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [AXI_ADDR_W-1:0] aw_addr_reg;
  logic [AXI_DATA_W-1:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [AXI_DATA_W-1:0] rdata_reg;
  logic [PIN_COUNT-1:0] pin_level;

  logic scaler_to_wdt;
  logic [2:0] ratio;
  logic [SCALER_W-1:0] scaler_mask;
  logic wdt_enabled;
  logic base_tick;
  logic wdt_overflow;
  logic ext_edge;
  logic write_go;
  logic [REG_INDEX_W-1:0] write_idx;
  logic write_lane0;
  logic timer_write;
  logic scaler_clear;
  logic scaler_event;
  logic timer_step;
  logic [7:0] read_byte;
  logic read_hit;

  // The factory bit is a strap from outside the clock domain, so it is filtered like a pin.
  pin_level_filter #(
    .WIDTH(PIN_COUNT)
  ) u_pin_filter (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin({i_config_wdt_enable, i_timer_zero_ext_clock}),
    .o_level(pin_level)
  );

  assign scaler_to_wdt = option_reg[OPT_ASSIGN_BIT]; // see R2
  assign ratio = option_reg[OPT_RATIO_LSB +: 3];
  assign scaler_mask = ratio_mask(ratio, scaler_to_wdt); // see R3
  assign wdt_enabled = pin_level[PIN_CONFIG_WDT] | watchdog_control_reg[WATCHDOG_CONTROL_ENABLE_BIT]; // see R13 see R14
  assign base_tick = wdt_enabled && (base_cnt_reg == WDT_BASE_LAST); // see R8
  // A clear or sleep in the tick cycle wins, so software that clears just in time is never reset.
  assign wdt_overflow = base_tick && !i_watchdog_clear_instr && !i_sleep_instr
                        && (!scaler_to_wdt || scaler_reg == scaler_mask); // see R3 see R8
  assign ext_edge = option_reg[OPT_EDGE_BIT] ? (ext_prev_reg && !pin_level[PIN_EXT_CLOCK])
                                            : (!ext_prev_reg && pin_level[PIN_EXT_CLOCK]); // see R15

  assign write_go = aw_held_reg && w_held_reg && !bvalid_reg;
  assign write_idx = reg_index(aw_addr_reg);
  assign write_lane0 = write_go && w_strb_reg[0];
  assign timer_write = write_lane0 && (write_idx == IDX_TIMER_ZERO_COUNT);

  assign scaler_clear = (i_watchdog_clear_instr && scaler_to_wdt) // see R4
                        || (timer_write && !scaler_to_wdt) // see R5
                        || (i_sleep_instr && scaler_to_wdt); // see R6
  assign scaler_event = scaler_to_wdt ? base_tick : ext_edge; // see R1
  assign timer_step = ext_edge && (scaler_to_wdt || scaler_reg == scaler_mask); // see R18

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= pin_level[PIN_EXT_CLOCK];
    end
  end

  // Watchdog base counter; it stands in for the free-running RC time base and keeps going in sleep.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      base_cnt_reg <= '0;
    end else if (wdt_overflow || i_watchdog_clear_instr || i_sleep_instr) begin // see R4 see R6
      base_cnt_reg <= '0;
    end else if (!wdt_enabled || base_tick) begin
      base_cnt_reg <= '0;
    end else begin
      base_cnt_reg <= base_cnt_reg + 1'b1; // see R7
    end
  end

  // The single scaler, counting either ticks or external edges up to the selected terminal count.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scaler_reg <= '0;
    end else if (wdt_overflow || scaler_clear) begin
      scaler_reg <= '0;
    end else if (scaler_event) begin
      scaler_reg <= (scaler_reg == scaler_mask) ? '0 : scaler_reg + 1'b1; // see R1 see R3
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer_zero_reg <= TIMER_ZERO_RESET;
      t0_ovf_reg <= 1'b0;
    end else if (wdt_overflow) begin
      timer_zero_reg <= TIMER_ZERO_RESET;
      t0_ovf_reg <= 1'b0;
    end else if (timer_write) begin
      timer_zero_reg <= w_data_reg[7:0];
      t0_ovf_reg <= 1'b0;
    end else begin
      timer_zero_reg <= timer_step ? timer_zero_reg + 1'b1 : timer_zero_reg;
      t0_ovf_reg <= timer_step && (timer_zero_reg == 8'hFF);
    end
  end

  // An overflow acts as a chip reset for the option, control, timer zero and sleep registers, so the period returns to 128 ms.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      option_reg <= OPTION_RESET;
    end else if (wdt_overflow) begin
      option_reg <= OPTION_RESET; // see R8
    end else if (write_lane0 && write_idx == IDX_SCALER_OPTION_CONTROL) begin
      option_reg <= w_data_reg[7:0] & OPTION_WRITE_MASK; // see R2
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      watchdog_control_reg <= WATCHDOG_CONTROL_RESET;
    end else if (wdt_overflow) begin
      watchdog_control_reg <= WATCHDOG_CONTROL_RESET;
    end else if (write_lane0 && write_idx == IDX_WATCHDOG_CONTROL) begin
      watchdog_control_reg <= w_data_reg[7:0] & WATCHDOG_CONTROL_WRITE_MASK; // see R13
    end
  end

  // Only power-on, the instruction events and an overflow move the flags; bus writes never reach them.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timeout_flag_reg <= 1'b1;
    end else if (wdt_overflow) begin
      timeout_flag_reg <= 1'b0; // see R9 see R11 see R20
    end else if (i_watchdog_clear_instr || i_sleep_instr) begin
      timeout_flag_reg <= 1'b1; // see R9 see R12
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      powerdown_flag_reg <= 1'b1;
    end else if (i_watchdog_clear_instr) begin
      powerdown_flag_reg <= 1'b1; // see R10 see R12
    end else if (i_sleep_instr) begin
      powerdown_flag_reg <= 1'b0; // see R10 see R11 see R20
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sleeping_reg <= 1'b0;
    end else if (wdt_overflow) begin
      sleeping_reg <= 1'b0;
    end else if (i_sleep_instr) begin
      sleeping_reg <= 1'b1;
    end else if (i_wake_event) begin
      sleeping_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wdt_reset_reg <= 1'b0;
    end else begin
      wdt_reset_reg <= wdt_overflow; // see R7
    end
  end

  // Write channel: address and data are taken in either order, then one response follows both.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= i_s_axi_awaddr;
    end else if (write_go) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= 4'h0;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= i_s_axi_wdata;
      w_strb_reg <= i_s_axi_wstrb;
    end else if (write_go) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= AXI_RESP_OKAY;
    end else if (write_go) begin
      bvalid_reg <= 1'b1;
      case (write_idx)
        IDX_TIMER_ZERO_COUNT, IDX_CORE_STATUS_FLAGS, IDX_SCALER_OPTION_CONTROL, IDX_WATCHDOG_CONTROL: begin
          bresp_reg <= AXI_RESP_OKAY;
        end
        default: begin
          bresp_reg <= AXI_RESP_SLVERR;
        end
      endcase
    end else if (i_s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_comb begin
    read_byte = 8'h00;
    read_hit = 1'b1;
    case (reg_index(i_s_axi_araddr))
      IDX_TIMER_ZERO_COUNT: begin
        read_byte = timer_zero_reg;
      end
      IDX_CORE_STATUS_FLAGS: begin
        read_byte[STAT_TIMEOUT_BIT] = timeout_flag_reg;
        read_byte[STAT_POWERDOWN_BIT] = powerdown_flag_reg;
      end
      IDX_SCALER_OPTION_CONTROL: begin
        read_byte = option_reg;
      end
      IDX_WATCHDOG_CONTROL: begin
        read_byte = watchdog_control_reg; // see R13
      end
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= AXI_RESP_OKAY;
      rdata_reg <= '0;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= read_hit ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
      rdata_reg <= {24'h000000, read_byte};
    end else if (i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign o_s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign o_s_axi_wready = !w_held_reg && !bvalid_reg;
  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp = bresp_reg;
  assign o_s_axi_arready = !rvalid_reg;
  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rresp = rresp_reg;
  assign o_s_axi_rdata = rdata_reg;
  assign o_wdt_reset = wdt_reset_reg;
  assign o_sleeping = sleeping_reg;
  assign o_timer_zero_overflow = t0_ovf_reg;
  assign o_timeout_flag = timeout_flag_reg;
  assign o_powerdown_flag = powerdown_flag_reg;

  sequence seq_clear_on_watchdog;
    i_watchdog_clear_instr && scaler_to_wdt;
  endsequence

  sequence seq_counts_zeroed;
    scaler_reg == '0 && base_cnt_reg == '0;
  endsequence

  sequence seq_disabled_two;
    !wdt_enabled [*2];
  endsequence

  AST_CLEAR_ZEROES_BOTH: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R4
    seq_clear_on_watchdog |=> seq_counts_zeroed)
    else $error("Clear-watchdog left a count nonzero.");

  AST_TIMER_WRITE_ZEROES_SCALER: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R5
    timer_write && !scaler_to_wdt |=> scaler_reg == '0 && timer_zero_reg == $past(w_data_reg[7:0]))
    else $error("Timer zero write did not zero the scaler.");

  AST_SLEEP_ZEROES_WATCHDOG: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R6
    i_sleep_instr |=> base_cnt_reg == '0 && sleeping_reg && !powerdown_flag_reg == !$past(i_watchdog_clear_instr))
    else $error("Sleep did not zero the watchdog count.");

  AST_OVERFLOW_CLEARS_TIMEOUT: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R9
    wdt_overflow |=> !timeout_flag_reg && wdt_reset_reg ##1 !wdt_reset_reg)
    else $error("Overflow did not clear the timeout flag for one reset pulse.");

  AST_OVERFLOW_KEEPS_POWERDOWN: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R10
    wdt_overflow |=> $stable(powerdown_flag_reg))
    else $error("Overflow changed the power-down flag.");

  AST_DISABLED_HOLDS_ZERO: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R14
    seq_disabled_two |-> base_cnt_reg == '0 && !wdt_overflow)
    else $error("Disabled watchdog kept counting.");

  AST_OVERFLOW_AT_RATIO: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R3
    wdt_overflow |-> base_cnt_reg == WDT_BASE_LAST && (!scaler_to_wdt || scaler_reg == scaler_mask))
    else $error("Overflow outside the terminal count.");

  AST_OVERFLOW_RESTORES_OPTION: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R8
    wdt_overflow |=> option_reg == OPTION_RESET && watchdog_control_reg == WATCHDOG_CONTROL_RESET)
    else $error("Overflow did not restore the period default.");

  AST_STATUS_WRITE_IGNORED: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see R12
    write_go && write_idx == IDX_CORE_STATUS_FLAGS && !wdt_overflow && !i_watchdog_clear_instr && !i_sleep_instr
    |=> $stable(timeout_flag_reg) && $stable(powerdown_flag_reg))
    else $error("Status write moved a flag.");
endmodule

// ---- src/wdt_scaler_pkg.sv ----
/*
  Shared constants of the watchdog, shared scaler and reset-cause flags block:
  register indices, field positions, reset values and timing figures.
  Assumes a single 25 MHz clock and 32-bit AXI4-Lite register access.
*/
package wdt_scaler_pkg;
  localparam int unsigned CLK_FREQ_HZ = 25_000_000;
  localparam int unsigned WDT_BASE_TIME_MS = 16;
  localparam int unsigned WDT_BASE_CYCLES = CLK_FREQ_HZ / 1000 * WDT_BASE_TIME_MS;
  localparam int unsigned WDT_BASE_CNT_W = 19;

  localparam int unsigned AXI_ADDR_W = 12;
  localparam int unsigned AXI_DATA_W = 32;
  localparam int unsigned REG_INDEX_W = 10;
  localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_TIMER_ZERO_COUNT = 10'h001;
  localparam logic [9:0] IDX_CORE_STATUS_FLAGS = 10'h003;
  localparam logic [9:0] IDX_SCALER_OPTION_CONTROL = 10'h081;
  localparam logic [9:0] IDX_WATCHDOG_CONTROL = 10'h089;

  localparam int unsigned SCALER_W = 8;
  localparam int unsigned OPT_RATIO_LSB = 0;
  localparam int unsigned OPT_ASSIGN_BIT = 3;
  localparam int unsigned OPT_EDGE_BIT = 4;
  localparam int unsigned STAT_POWERDOWN_BIT = 3;
  localparam int unsigned STAT_TIMEOUT_BIT = 4;
  localparam int unsigned WATCHDOG_CONTROL_ENABLE_BIT = 0;

  localparam logic [7:0] OPTION_RESET = 8'h7B;
  localparam logic [7:0] OPTION_WRITE_MASK = 8'h7F;
  localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h00;
  localparam logic [7:0] WATCHDOG_CONTROL_WRITE_MASK = 8'h01;
  localparam logic [7:0] TIMER_ZERO_RESET = 8'h00;

  localparam int unsigned PIN_COUNT = 2;
  localparam int unsigned PIN_EXT_CLOCK = 0;
  localparam int unsigned PIN_CONFIG_WDT = 1;
endpackage

// ---- test/cpu_core_model.sv ----
/*
  Model of the CPU core side: clear-watchdog and sleep strobes, and the
  external count pin of timer zero. Assumes one bench process calls its tasks.
*/
`timescale 1ns/10ps
module cpu_core_model (
  input wire logic i_clk,
  output logic o_watchdog_clear_instr,
  output logic o_sleep_instr,
  output logic o_timer_zero_ext_clock
);
  initial begin
    o_watchdog_clear_instr = 1'b0;
    o_sleep_instr = 1'b0;
    o_timer_zero_ext_clock = 1'b0;
  end
  // Clears are issued by the main sequence only, never from a handler.
  task automatic clear_wdt();
    @(posedge i_clk);
    o_watchdog_clear_instr <= 1'b1;
    @(posedge i_clk);
    o_watchdog_clear_instr <= 1'b0;
  endtask
  task automatic do_sleep();
    @(posedge i_clk);
    o_sleep_instr <= 1'b1;
    @(posedge i_clk);
    o_sleep_instr <= 1'b0;
  endtask
  // Each level is held ten cycles so the input filter never drops an edge.
  task automatic pin(input logic lv);
    @(posedge i_clk);
    o_timer_zero_ext_clock <= lv;
    repeat (10) @(posedge i_clk);
  endtask
endmodule

// ---- test/watchdog_prescaler_reset_flags_test.sv ----
/*
  Self-checking bench of the watchdog and shared scaler block.
  Assumes the core model drives the strobes and the register bus is AXI4-Lite.
*/
`timescale 1ns/10ps
module watchdog_prescaler_reset_flags_test;
  import wdt_scaler_pkg::*;
  // A short base count keeps every watchdog period within a few thousand cycles.
  localparam int P = 8;
  localparam logic [11:0] A_TMR = {IDX_TIMER_ZERO_COUNT, 2'b00};
  localparam logic [11:0] A_STA = {IDX_CORE_STATUS_FLAGS, 2'b00};
  localparam logic [11:0] A_OPT = {IDX_SCALER_OPTION_CONTROL, 2'b00};
  localparam logic [11:0] A_CTL = {IDX_WATCHDOG_CONTROL, 2'b00};
  logic i_clk, i_reset_n, strap, awvalid, wvalid, bready, arvalid, rready, wake;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, clr, slp, ext;
  logic wdt_rst, sleeping, t0_ovf, to_flag, pd_flag;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  int err_count, num_checks, rst_cnt, ovf_cnt, c, r, m;

  cpu_core_model cpu (.i_clk(i_clk), .o_watchdog_clear_instr(clr), .o_sleep_instr(slp),
    .o_timer_zero_ext_clock(ext));
  wdt_scaler_core #(.WDT_BASE_CYCLES_P(P)) DUT (
    .i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_watchdog_clear_instr(clr), .i_sleep_instr(slp), .i_wake_event(wake),
    .i_timer_zero_ext_clock(ext), .i_config_wdt_enable(strap), .o_wdt_reset(wdt_rst),
    .o_sleeping(sleeping), .o_timer_zero_overflow(t0_ovf), .o_timeout_flag(to_flag),
    .o_powerdown_flag(pd_flag));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (wdt_rst === 1'b1) rst_cnt <= rst_cnt + 1;
  always @(posedge i_clk) if (t0_ovf === 1'b1) ovf_cnt <= ovf_cnt + 1;

  function automatic int wdt_period(int k);
    return P << k;
  endfunction
  function automatic int tmr_steps(int e, int k);
    return e >> (k + 1);
  endfunction

  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic hang();
    err_count++;
    end_sim();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (40) begin
      @(negedge i_clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      resp = bresp;
      @(posedge i_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  task automatic rdr(input logic [11:0] a);
    logic ta, tb;
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (40) begin
      @(negedge i_clk);
      ta = arvalid & arready;
      tb = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge i_clk);
      if (ta) arvalid <= 1'b0;
      if (tb) begin
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rdr(a);
    chk({30'h0, resp}, {30'h0, AXI_RESP_OKAY});
    chk(rd, e);
  endtask
  task automatic wait_rst(output int n);
    n = 0;
    while (wdt_rst !== 1'b1) begin
      if (n > 1100) hang();
      @(negedge i_clk);
      n++;
    end
    repeat (2) @(posedge i_clk);
  endtask
  task automatic per_chk(input int n, input int e);
    chk({31'h0, (n >= e - 2) && (n <= e + 6)}, 32'h1);
  endtask

  initial begin
    i_reset_n = 1'b0;
    strap = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    wake = 1'b0;
    err_count = 0;
    num_checks = 0;
    rst_cnt = 0;
    ovf_cnt = 0;
    void'($urandom(86094));
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rchk(A_OPT, 32'h7B);
    rchk(A_CTL, 32'h00);
    rchk(A_STA, 32'h18);
    rdr(12'h300);
    chk({30'h0, resp}, {30'h0, AXI_RESP_SLVERR});
    wr(12'h300, 8'h01);
    chk({30'h0, resp}, {30'h0, AXI_RESP_SLVERR});
    wr(A_STA, 8'h00);
    chk({30'h0, resp}, {30'h0, AXI_RESP_OKAY});
    rchk(A_STA, 32'h18);
    wr(A_CTL, 8'hFF);
    rchk(A_CTL, 32'h01);
    wr(A_CTL, 8'h00);
    // A write whose low byte lane is off must leave the enable untouched.
    wstrb <= 4'hE;
    wr(A_CTL, 8'h01);
    chk({30'h0, resp}, {30'h0, AXI_RESP_OKAY});
    wstrb <= 4'hF;
    rchk(A_CTL, 32'h00);
    for (m = 0; m < 4; m++) begin
      r = (m == 0) ? 7 : $urandom_range(6, 0);
      wr(A_OPT, 8'h07);
      wr(A_TMR, 8'h00);
      wr(A_OPT, 8'h0F);
      cpu.clear_wdt();
      wr(A_OPT, 8'h08 | 8'(r));
      wr(A_CTL, 8'h01);
      cpu.clear_wdt();
      wait_rst(c);
      per_chk(c, wdt_period(r));
      rchk(A_STA, 32'h08);
      rchk(A_OPT, 32'h7B);
    end
    wr(A_CTL, 8'h01);
    repeat (40) @(posedge i_clk);
    cpu.do_sleep();
    rchk(A_STA, 32'h10);
    wait_rst(c);
    chk({31'h0, c >= 50}, 32'h1);
    chk({31'h0, sleeping}, 32'h0);
    rchk(A_STA, 32'h00);
    cpu.clear_wdt();
    rchk(A_STA, 32'h18);
    wr(A_CTL, 8'h01);
    m = rst_cnt;
    repeat (8) begin
      repeat (40) @(posedge i_clk);
      cpu.clear_wdt();
    end
    chk(rst_cnt, m);
    wr(A_CTL, 8'h00);
    repeat (600) @(posedge i_clk);
    chk(rst_cnt, m);
    @(posedge i_clk);
    strap <= 1'b1;
    cpu.clear_wdt();
    wait_rst(c);
    per_chk(c, wdt_period(3));
    strap <= 1'b0;
    cpu.clear_wdt();
    wr(A_OPT, 8'h00);
    wr(A_TMR, 8'h00);
    cpu.pin(1'b1);
    cpu.pin(1'b0);
    wr(A_TMR, 8'h10);
    cpu.pin(1'b1);
    cpu.pin(1'b0);
    rchk(A_TMR, 32'h10);
    cpu.pin(1'b1);
    cpu.pin(1'b0);
    rchk(A_TMR, 32'h11);
    for (m = 0; m < 3; m++) begin
      r = $urandom_range(2, 0);
      c = $urandom_range(3, 1) << (r + 1);
      wr(A_OPT, 8'(r));
      wr(A_TMR, 8'h00);
      repeat (c) begin
        cpu.pin(1'b1);
        cpu.pin(1'b0);
      end
      rchk(A_TMR, 32'(tmr_steps(c, r)));
    end
    wr(A_OPT, 8'h18);
    wr(A_TMR, 8'h00);
    cpu.pin(1'b1);
    rchk(A_TMR, 32'h00);
    cpu.pin(1'b0);
    rchk(A_TMR, 32'h01);
    wr(A_TMR, 8'hFF);
    m = ovf_cnt;
    cpu.pin(1'b1);
    cpu.pin(1'b0);
    rchk(A_TMR, 32'h00);
    chk(ovf_cnt, m + 1);
    cpu.do_sleep();
    @(negedge i_clk);
    chk({29'h0, to_flag, pd_flag, sleeping}, 32'h5);
    @(posedge i_clk);
    wake <= 1'b1;
    @(posedge i_clk);
    wake <= 1'b0;
    @(negedge i_clk);
    chk({29'h0, to_flag, pd_flag, sleeping}, 32'h4);
    end_sim();
  end
endmodule
